// ---- core/fcd_pkg.sv ----
package fcd_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int INDEX_W = 6;
  localparam int REG_W   = 16;

  // ------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [INDEX_W-1:0] IDX_PREDIV_CFG = 6'h08;
  localparam logic [INDEX_W-1:0] IDX_DIV_CFG    = 6'h09;
  localparam logic [INDEX_W-1:0] IDX_STATUS     = 6'h3e;
  localparam logic [INDEX_W-1:0] IDX_REF_CTRL   = 6'h3f;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_DIV_CFG    = 16'h001e;
  localparam logic [REG_W-1:0] RST_PREDIV_CFG = 16'h0120;
  localparam logic [REG_W-1:0] RST_REF_CTRL   = 16'h0000;

  // ------------------------------------------------------------------
  // divider configuration fields
  // ------------------------------------------------------------------
  localparam int DIV_RATIO_LSB  = 0;
  localparam int DIV_RATIO_W    = 10;
  localparam int DIV_RSVD_BIT   = 10;
  localparam int DIV_BYPASS_BIT = 11;
  localparam int DIV_PD_BIT     = 12;
  localparam int SYNC_EN_BIT    = 13;
  localparam int BIAS_LSB       = 14;
  localparam int BIAS_W         = 2;

  // neighbouring register: bits 8:0 writable, 15:9 read zero
  localparam int PRE_LSB        = 6;
  localparam int PRE_W          = 3;
  localparam logic [REG_W-1:0] PREDIV_WMASK = 16'h01ff;

  // own control register: ref enable, also turns on sync path and capture
  localparam int REF_EN_BIT     = 0;
  localparam logic [REG_W-1:0] REF_WMASK    = 16'h0001;

  // status bits
  localparam int ST_SYNC_BIT    = 0;
  localparam int ST_DIV_RUN_BIT = 1;
  localparam int ST_BYPASS_BIT  = 2;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam logic [PRE_W-1:0] PRE_DIV1 = 3'h1;
  localparam logic [PRE_W-1:0] PRE_DIV2 = 3'h2;
  localparam logic [PRE_W-1:0] PRE_DIV4 = 3'h4;

  localparam logic [DIV_RATIO_W-1:0] DIV_MIN = 10'h002;

  localparam logic [BIAS_W-1:0] BIAS_1V3 = 2'h0;
  localparam logic [BIAS_W-1:0] BIAS_1V1 = 2'h1;
  localparam logic [BIAS_W-1:0] BIAS_1V5 = 2'h2;
  localparam logic [BIAS_W-1:0] BIAS_OFF = 2'h3;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // reserved pre-divider codes behave as the reset ratio
  function automatic logic [PRE_W-1:0] fcd_pre_ratio(input logic [PRE_W-1:0] code);
    if (code == PRE_DIV1 || code == PRE_DIV2 || code == PRE_DIV4) begin
      return code;
    end
    return PRE_DIV4;
  endfunction : fcd_pre_ratio

  // reserved main divider codes 0 and 1 behave as the smallest ratio
  function automatic logic [DIV_RATIO_W-1:0] fcd_main_ratio(input logic [DIV_RATIO_W-1:0] code);
    if (code < DIV_MIN) begin
      return DIV_MIN;
    end
    return code;
  endfunction : fcd_main_ratio

endpackage : fcd_pkg

// ---- core/fcd_predivider.sv ----
module fcd_predivider
  import fcd_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [PRE_W-1:0] ratio_code,
  output logic                  pre_tick
);

  // ------------------------------------------------------------------
  // pre-divider counter
  // ------------------------------------------------------------------
  logic [PRE_W-1:0] cnt_ff;
  logic [PRE_W-1:0] nxt_cnt;
  logic             tick_ff;
  logic             nxt_tick;
  logic [PRE_W-1:0] ratio;

  always_comb begin
    ratio = fcd_pre_ratio(ratio_code); // [R9]
    if (cnt_ff >= ratio - PRE_DIV1) begin
      nxt_cnt  = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt  = cnt_ff + PRE_DIV1;
      nxt_tick = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign pre_tick = tick_ff;

endmodule : fcd_predivider

// ---- core/fcd_main_divider.sv ----
module fcd_main_divider
  import fcd_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   pre_tick,
  input  wire logic [DIV_RATIO_W-1:0] ratio_code,
  input  wire logic                   powerdown,
  output logic                        main_tick
);

  // ------------------------------------------------------------------
  // main divider counter, advanced by pre-divider ticks
  // ------------------------------------------------------------------
  logic [DIV_RATIO_W-1:0] cnt_ff;
  logic [DIV_RATIO_W-1:0] nxt_cnt;
  logic                   tick_ff;
  logic                   nxt_tick;
  logic [DIV_RATIO_W-1:0] ratio;

  always_comb begin
    ratio    = fcd_main_ratio(ratio_code); // [R1]
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (powerdown) begin
      nxt_cnt = '0; // [R3]
    end else if (pre_tick) begin
      if (cnt_ff >= ratio - 10'h001) begin
        nxt_cnt  = '0;
        nxt_tick = 1'b1; // [R10]
      end else begin
        nxt_cnt = cnt_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign main_tick = tick_ff;

endmodule : fcd_main_divider

// ---- core/fcd_top.sv ----
// What this block and its software do
// R1: ten-bit main ratio, reset 30, codes 0-1 reserved
// R2: bypass bit routes pre-divider output straight out
// R3: powerdown bit stops main divider, pre-divider runs
// R4: software keeps bypass/powerdown zero at pre 2,4
// R5: software adjusts two external registers around bypass
// R6: sync bit enables sync path and capture
// R7: software writes zero to reserved bit ten
// R8: bias field: 1.3V, 1.1V, 1.5V, off
// R9: pre-divider field selects one, two or four
// R10: output rate is input over pre times main
//
// The Avalon-MM register port was chosen for this implementation.
module fcd_top
  import fcd_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   fabric_clock_output,
  output logic                   sync_path_enable,
  output logic                   capture_permit,
  output logic                   bias_sel_1v3,
  output logic                   bias_sel_1v1,
  output logic                   bias_sel_1v5,
  output logic                   bias_off
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // avalon slave handshake
  // ------------------------------------------------------------------
  logic                wait_ff;
  logic                nxt_wait;
  logic [DATA_W-1:0]   rdata_ff;
  logic [DATA_W-1:0]   nxt_rdata;
  logic [INDEX_W-1:0]  index;
  logic                accept;
  logic [REG_W-1:0]    lane_mask;

  assign index  = avs_address[ADDR_W-1:2];
  assign accept = (avs_read || avs_write) && !wait_ff;

  // byte enables of the low half select the bytes of a 16-bit register
  always_comb begin
    lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [REG_W-1:0] div_cfg_ff;
  logic [REG_W-1:0] nxt_div_cfg;
  logic [REG_W-1:0] pre_cfg_ff;
  logic [REG_W-1:0] nxt_pre_cfg;
  logic [REG_W-1:0] ref_ctrl_ff;
  logic [REG_W-1:0] nxt_ref_ctrl;
  logic [REG_W-1:0] status;

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                             input logic [REG_W-1:0] new_v,
                                             input logic [REG_W-1:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  always_comb begin
    nxt_div_cfg  = div_cfg_ff;
    nxt_pre_cfg  = pre_cfg_ff;
    nxt_ref_ctrl = ref_ctrl_ff;
    if (accept && avs_write) begin
      case (index)
        // reserved bit ten is stored as written; software keeps it zero [R7]
        IDX_DIV_CFG:  nxt_div_cfg  = merge(div_cfg_ff, avs_writedata[REG_W-1:0], lane_mask);
        IDX_PREDIV_CFG: begin
          nxt_pre_cfg = merge(pre_cfg_ff, avs_writedata[REG_W-1:0],
                              lane_mask & PREDIV_WMASK);
        end
        IDX_REF_CTRL: begin
          nxt_ref_ctrl = merge(ref_ctrl_ff, avs_writedata[REG_W-1:0],
                               lane_mask & REF_WMASK);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      div_cfg_ff  <= RST_DIV_CFG; // [R1] [R8]
      pre_cfg_ff  <= RST_PREDIV_CFG; // [R9]
      ref_ctrl_ff <= RST_REF_CTRL;
    end else begin
      div_cfg_ff  <= nxt_div_cfg;
      pre_cfg_ff  <= nxt_pre_cfg;
      ref_ctrl_ff <= nxt_ref_ctrl;
    end
  end

  // ------------------------------------------------------------------
  // field views
  // ------------------------------------------------------------------
  logic [DIV_RATIO_W-1:0] main_ratio;
  logic                   bypass;
  logic                   powerdown;
  logic                   sync_en;
  logic [BIAS_W-1:0]      bias_code;
  logic [PRE_W-1:0]       pre_code;
  logic                   ref_en;

  assign main_ratio = div_cfg_ff[DIV_RATIO_LSB +: DIV_RATIO_W];
  assign bypass     = div_cfg_ff[DIV_BYPASS_BIT];
  assign powerdown  = div_cfg_ff[DIV_PD_BIT];
  assign sync_en    = div_cfg_ff[SYNC_EN_BIT];
  assign bias_code  = div_cfg_ff[BIAS_LSB +: BIAS_W];
  assign pre_code   = pre_cfg_ff[PRE_LSB +: PRE_W];
  assign ref_en     = ref_ctrl_ff[REF_EN_BIT];

  // ------------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------------
  logic pre_tick;
  logic main_tick;

  // bypass/powerdown at pre ratio 2 or 4 is left to software [R4]
  fcd_predivider u_pre (
    .clock      (clock),
    .rst_n      (rst_n_ff),
    .ratio_code (pre_code),
    .pre_tick   (pre_tick)
  );

  fcd_main_divider u_main (
    .clock      (clock),
    .rst_n      (rst_n_ff),
    .pre_tick   (pre_tick),
    .ratio_code (main_ratio),
    .powerdown  (powerdown),
    .main_tick  (main_tick)
  );

  // ------------------------------------------------------------------
  // outputs and status
  // ------------------------------------------------------------------
  logic fclk_ff;
  logic nxt_fclk;
  logic sync_ff;
  logic nxt_sync;
  logic [3:0] bias_ff;
  logic [3:0] nxt_bias;

  always_comb begin
    nxt_fclk = bypass ? pre_tick : main_tick; // [R2] [R10]
    nxt_sync = sync_en || ref_en; // [R6]
    case (bias_code) // [R8]
      BIAS_1V3: nxt_bias = 4'h1;
      BIAS_1V1: nxt_bias = 4'h2;
      BIAS_1V5: nxt_bias = 4'h4;
      BIAS_OFF: nxt_bias = 4'h8;
      default:  nxt_bias = 4'h1;
    endcase
    status                 = '0;
    status[ST_SYNC_BIT]    = sync_ff;
    status[ST_DIV_RUN_BIT] = !powerdown;
    status[ST_BYPASS_BIT]  = bypass;
  end

  always_comb begin
    nxt_wait  = 1'b1;
    nxt_rdata = '0;
    if ((avs_read || avs_write) && wait_ff) begin
      nxt_wait = 1'b0;
      if (avs_read) begin
        case (index)
          IDX_DIV_CFG:    nxt_rdata = {16'h0000, div_cfg_ff};
          IDX_PREDIV_CFG: nxt_rdata = {16'h0000, pre_cfg_ff};
          IDX_REF_CTRL:   nxt_rdata = {16'h0000, ref_ctrl_ff};
          IDX_STATUS:     nxt_rdata = {16'h0000, status};
          default:        nxt_rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
      fclk_ff  <= 1'b0;
      sync_ff  <= 1'b0;
      bias_ff  <= 4'h1;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
      fclk_ff  <= nxt_fclk;
      sync_ff  <= nxt_sync;
      bias_ff  <= nxt_bias;
    end
  end

  // external register edits around bypass are software's job [R5]
  assign avs_waitrequest     = wait_ff;
  assign avs_readdata        = rdata_ff;
  assign fabric_clock_output = fclk_ff;
  assign sync_path_enable    = sync_ff;
  assign capture_permit      = sync_ff;
  assign bias_sel_1v3        = bias_ff[0];
  assign bias_sel_1v1        = bias_ff[1];
  assign bias_sel_1v5        = bias_ff[2];
  assign bias_off            = bias_ff[3];

endmodule : fcd_top

// ---- tb/fcd_props.sv ----
// ------------------------------------------------------------------
// port checker for the divider configuration block
// ------------------------------------------------------------------
module fcd_props
  import fcd_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              fabric_clock_output,
  input wire logic              sync_path_enable,
  input wire logic              capture_permit,
  input wire logic              bias_sel_1v3,
  input wire logic              bias_sel_1v1,
  input wire logic              bias_sel_1v5,
  input wire logic              bias_off
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence div_wr_s;
    avs_write && !avs_waitrequest && avs_address[7:2] == IDX_DIV_CFG && avs_byteenable[1];
  endsequence

  wait_answer_a: assert property (req_s |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  idle_rdata_a: assert property (avs_waitrequest |-> avs_readdata == 32'h0000_0000)
    else $error("read data not zero outside an answer");
  upper_rdata_a: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  bias_onehot_a: assert property ($onehot({bias_off, bias_sel_1v5, bias_sel_1v1, bias_sel_1v3}))
    else $error("bias select outputs not one-hot");
  bias_off_a: assert property (div_wr_s ##0 avs_writedata[15:14] == BIAS_OFF |-> ##[1:3] bias_off)
    else $error("bias off not selected after write");
  bias_low_a: assert property (div_wr_s ##0 avs_writedata[15:14] == BIAS_1V1 |-> ##[1:3] bias_sel_1v1)
    else $error("bias 1.1 not selected after write");
  sync_follow_a: assert property (div_wr_s ##0 avs_writedata[13] |-> ##[1:3] sync_path_enable)
    else $error("sync path not enabled after write");
  capture_same_a: assert property (capture_permit == sync_path_enable)
    else $error("capture permit differs from sync path enable");
endmodule : fcd_props

// ---- tb/testbench.sv ----
module testbench
  import fcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [ADDR_W-1:0] A_DIV = {IDX_DIV_CFG, 2'h0};
  localparam logic [ADDR_W-1:0] A_PRE = {IDX_PREDIV_CFG, 2'h0};
  localparam logic [ADDR_W-1:0] A_REF = {IDX_REF_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, 2'h0};
  logic              clock = 1'h0;
  logic              rst_b = 1'h0;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic              avs_read = 1'h0;
  logic              avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [3:0]        avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest, fabric_clock_output, sync_path_enable, capture_permit;
  logic              bias_sel_1v3, bias_sel_1v1, bias_sel_1v5, bias_off;
  int                num_errors = 0;
  int                samples_checked = 0;
  int                c;
  logic [DATA_W-1:0] q;
  logic [REG_W-1:0]  t_pre [6] = '{16'h0060, 16'h00a0, 16'h0120, 16'h0060, 16'h0060, 16'h0060};
  logic [REG_W-1:0]  t_div [6] = '{16'h0003, 16'h0005, 16'h0002, 16'h03ff, 16'h0805, 16'h1805};
  int                t_per [6] = '{3, 10, 8, 1023, 1, 1};
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

  fcd_top dut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fabric_clock_output(fabric_clock_output), .sync_path_enable(sync_path_enable),
    .capture_permit(capture_permit), .bias_sel_1v3(bias_sel_1v3), .bias_sel_1v1(bias_sel_1v1),
    .bias_sel_1v5(bias_sel_1v5), .bias_off(bias_off));

  initial begin
    forever #25 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // bus and timing tasks
  // ------------------------------------------------------------------
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic bus_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
                        input logic [3:0] be, output logic [DATA_W-1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    avs_address    <= a;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      give_verdict();
    end
  endtask : bus_op

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    logic [DATA_W-1:0] r;
    bus_op(1'b1, a, d, 4'h3, r);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] r;
    bus_op(1'b0, a, 16'h0000, 4'h3, r);
    `CHK(r, e)
  endtask : rd

  task automatic next_tick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (fabric_clock_output !== 1'b1 && n < 1100);
    if (n >= 1100) begin
      num_errors++;
      give_verdict();
    end
  endtask : next_tick

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd(A_DIV, 32'h001e);
    rd(A_PRE, 32'h0120);
    rd(A_REF, 32'h0000);
    rd(8'h40, 32'h0000);
    `CHK({bias_off, bias_sel_1v5, bias_sel_1v1, bias_sel_1v3}, 4'h1)
    // pre-divider is four here, so bypass and powerdown stay zero
    wr(A_DIV, 16'he3ff);
    rd(A_DIV, 32'he3ff);
    for (int b = 0; b < 4; b++) begin
      wr(A_DIV, {b[1:0], 14'h001e});
      repeat (3) @(posedge clock);
      `CHK({bias_off, bias_sel_1v5, bias_sel_1v1, bias_sel_1v3}, 4'h1 << b)
    end
    `CHK(sync_path_enable, 1'b0)
    wr(A_REF, 16'hffff);
    rd(A_REF, 32'h0001);
    `CHK({sync_path_enable, capture_permit}, 2'h3)
    wr(A_REF, 16'h0000);
    bus_op(1'b1, A_DIV, 16'h20ff, 4'h2, q);
    rd(A_DIV, 32'h201e);
    repeat (2) @(posedge clock);
    `CHK({sync_path_enable, capture_permit}, 2'h3)
    rd(A_STAT, 32'h0000_0003);
    // bypass is only set while the pre-divider is one
    for (int i = 0; i < 6; i++) begin
      wr(A_PRE, t_pre[i]);
      wr(A_DIV, t_div[i]);
      repeat (3) next_tick(c);
      `CHK(c, t_per[i])
    end
    wr(A_DIV, 16'h1005);
    repeat (4) @(posedge clock);
    c = 0;
    repeat (60) begin
      @(posedge clock);
      c += int'(fabric_clock_output !== 1'b0);
    end
    `CHK(c, 0)
    rd(A_STAT, 32'h0000_0000);
    give_verdict();
  end
endmodule : testbench

bind fcd_top fcd_props u_props (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .fabric_clock_output(fabric_clock_output),
  .sync_path_enable(sync_path_enable), .capture_permit(capture_permit),
  .bias_sel_1v3(bias_sel_1v3), .bias_sel_1v1(bias_sel_1v1), .bias_sel_1v5(bias_sel_1v5),
  .bias_off(bias_off));
